// file: hw/hsb_ctrl.sv
// control logic of a hot swap two-wire bus buffer with an apb register port
// assumes presetn low while the supply is locked out; pins are open drain,
// resolved outside from the output enables
//
// The APB interface to the registers and the address map were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module hsb_ctrl
    import hsb_pkg::*;
#(
    parameter int unsigned IDLE_COUNT = IDLE_CYCLES
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        backplane_data_line_in,
    output logic             backplane_data_line_out,
    output logic             backplane_data_line_oe,
    input  wire logic        backplane_clock_line_in,
    output logic             backplane_clock_line_out,
    output logic             backplane_clock_line_oe,
    input  wire logic        card_data_line_in,
    output logic             card_data_line_out,
    output logic             card_data_line_oe,
    input  wire logic        card_clock_line_in,
    output logic             card_clock_line_out,
    output logic             card_clock_line_oe,
    input  wire logic        enable_pin,
    output logic             ready,
    output logic             ready_oe,
    output logic             accel_enable,
    output logic             precharge_enable,
    output logic             low_power
);

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers and filters

    logic [IN_COUNT-1:0] pins_raw;
    logic [IN_COUNT-1:0] sync1_reg;
    logic [IN_COUNT-1:0] sync2_reg;
    logic [IN_COUNT-1:0] sync3_reg;
    logic [IN_COUNT-1:0] filt_reg;
    logic [IN_COUNT-1:0] filt_next;

    assign pins_raw = {enable_pin, card_clock_line_in, card_data_line_in,
                       backplane_clock_line_in, backplane_data_line_in};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_reg <= SYNC_RESET;
            sync2_reg <= SYNC_RESET;
            sync3_reg <= SYNC_RESET;
        end else begin
            sync1_reg <= pins_raw;
            sync2_reg <= sync1_reg;
            sync3_reg <= sync2_reg;
        end
    end

    // a change counts once stages two and three agree
    genvar gi;
    generate
        for (gi = 0; gi < IN_COUNT; gi++) begin : g_filt
            assign filt_next[gi] = (sync2_reg[gi] == sync3_reg[gi]) ?
                                   sync2_reg[gi] : filt_reg[gi];
        end
    endgenerate

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            filt_reg <= SYNC_RESET;
        end else begin
            filt_reg <= filt_next;
        end
    end

    logic bp_dat;
    logic bp_clk;
    logic card_dat;
    logic card_clk;
    logic ctrl_en_reg;
    logic enable_eff;

    assign bp_dat     = filt_reg[PIN_BP_DAT];
    assign bp_clk     = filt_reg[PIN_BP_CLK];
    assign card_dat   = filt_reg[PIN_CARD_DAT];
    assign card_clk   = filt_reg[PIN_CARD_CLK];
    assign enable_eff = filt_reg[PIN_ENABLE] & ctrl_en_reg;

    ////////////////////////////////////////////////////////////////////////
    // stop and idle detection on the backplane

    logic        bp_dat_prev_reg;
    logic        stop_seen;
    logic        idle_seen;
    logic [15:0] idle_cnt_reg;
    hsb_state_type state_reg;
    hsb_state_type state_next;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bp_dat_prev_reg <= 1'b1;
        end else begin
            bp_dat_prev_reg <= bp_dat;
        end
    end

    assign stop_seen = bp_dat & ~bp_dat_prev_reg & bp_clk;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            idle_cnt_reg <= 16'h0000;
        end else if (state_reg != ST_WAIT_BUS || !(bp_dat && bp_clk)) begin
            idle_cnt_reg <= 16'h0000;
        end else if (idle_cnt_reg != 16'(IDLE_COUNT)) begin
            idle_cnt_reg <= idle_cnt_reg + 16'h0001;
        end
    end

    assign idle_seen = (idle_cnt_reg == 16'(IDLE_COUNT));

    ////////////////////////////////////////////////////////////////////////
    // start-up sequence

    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            ST_LOCKOUT:   state_next = ST_WAIT_BUS;
            ST_WAIT_BUS: begin
                if (stop_seen || idle_seen) begin
                    state_next = ST_WAIT_CARD;
                end
            end
            ST_WAIT_CARD: begin
                if (card_dat && card_clk) begin
                    state_next = ST_CONNECTED;
                end
            end
            ST_CONNECTED: state_next = ST_CONNECTED;
            ST_SHUTDOWN:  state_next = ST_WAIT_BUS;
            default:      state_next = ST_LOCKOUT;
        endcase
        if (!enable_eff) begin
            state_next = ST_SHUTDOWN;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= ST_LOCKOUT;
        end else begin
            state_reg <= state_next;
        end
    end

    logic conn_next;
    assign conn_next = (state_next == ST_CONNECTED);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ready            <= 1'b0;
            ready_oe         <= 1'b1;
            accel_enable     <= 1'b0;
            precharge_enable <= 1'b1;
            low_power        <= 1'b0;
        end else begin
            ready            <= conn_next;
            ready_oe         <= ~conn_next;
            accel_enable     <= conn_next;
            precharge_enable <= ~conn_next && state_next != ST_SHUTDOWN;
            low_power        <= (state_next == ST_SHUTDOWN);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // connection circuitry, index 0 data, 1 clock

    logic [1:0]      drv_bp_reg;
    logic [1:0]      drv_card_reg;
    logic [1:0][2:0] hold_bp_reg;
    logic [1:0][2:0] hold_card_reg;
    logic [1:0]      bp_low;
    logic [1:0]      card_low;
    logic [1:0]      bp_ext;
    logic [1:0]      card_ext;

    // filter delay plus one: our own release reaches the filter this late
    localparam logic [2:0] BLIND_CYCLES = 3'(SYNC_STAGES + 1);

    assign bp_low   = ~{bp_clk, bp_dat};
    assign card_low = ~{card_clk, card_dat};

    // a side we drive, or released less than a filter delay ago, is blind:
    // its stale low would be passed back and the pair would oscillate
    genvar gc;
    generate
        for (gc = 0; gc < 2; gc++) begin : g_blind
            assign bp_ext[gc]   = bp_low[gc] & ~drv_bp_reg[gc]
                                  & (hold_bp_reg[gc] == 3'h0);
            assign card_ext[gc] = card_low[gc] & ~drv_card_reg[gc]
                                  & (hold_card_reg[gc] == 3'h0);
        end
    endgenerate

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            drv_bp_reg    <= 2'b00;
            drv_card_reg  <= 2'b00;
            hold_bp_reg   <= '0;
            hold_card_reg <= '0;
        end else begin
            for (int i = 0; i < 2; i++) begin
                if (!conn_next) begin
                    drv_bp_reg[i]    <= 1'b0;
                    drv_card_reg[i]  <= 1'b0;
                    hold_bp_reg[i]   <= 3'h0;
                    hold_card_reg[i] <= 3'h0;
                end else begin
                    // card low wins when both sides are pulled at once
                    drv_bp_reg[i]   <= card_ext[i];
                    drv_card_reg[i] <= bp_ext[i] & ~card_ext[i];
                    if (drv_bp_reg[i]) begin
                        hold_bp_reg[i] <= BLIND_CYCLES;
                    end else if (hold_bp_reg[i] != 3'h0) begin
                        hold_bp_reg[i] <= hold_bp_reg[i] - 3'h1;
                    end
                    if (drv_card_reg[i]) begin
                        hold_card_reg[i] <= BLIND_CYCLES;
                    end else if (hold_card_reg[i] != 3'h0) begin
                        hold_card_reg[i] <= hold_card_reg[i] - 3'h1;
                    end
                end
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            backplane_data_line_out  <= 1'b0;
            backplane_clock_line_out <= 1'b0;
            card_data_line_out       <= 1'b0;
            card_clock_line_out      <= 1'b0;
        end else begin
            backplane_data_line_out  <= 1'b0;
            backplane_clock_line_out <= 1'b0;
            card_data_line_out       <= 1'b0;
            card_clock_line_out      <= 1'b0;
        end
    end

    assign backplane_data_line_oe  = drv_bp_reg[0];
    assign backplane_clock_line_oe = drv_bp_reg[1];
    assign card_data_line_oe       = drv_card_reg[0];
    assign card_clock_line_oe      = drv_card_reg[1];

    ////////////////////////////////////////////////////////////////////////
    // apb slave, zero wait states

    function automatic logic hsb_hit(input logic [7:0] addr);
        hsb_hit = (addr == CTRL_OFFSET) || (addr == STATUS_OFFSET);
    endfunction : hsb_hit

    logic [31:0] status_word;
    logic        apb_setup;
    logic        apb_write;

    always_comb begin
        status_word = 32'h0000_0000;
        status_word[STAT_ST_LSB +: 5]  = state_reg;
        status_word[STAT_PIN_LSB +: 4] = {card_clk, card_dat, bp_clk, bp_dat};
        status_word[STAT_EN_BIT]       = filt_reg[PIN_ENABLE];
    end

    assign apb_setup = psel & ~penable;
    assign apb_write = psel & penable & pready & pwrite;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= apb_setup;
            pslverr <= apb_setup & ~hsb_hit(paddr);
            if (apb_setup && !pwrite && paddr == CTRL_OFFSET) begin
                prdata <= {31'h0000_0000, ctrl_en_reg};
            end else if (apb_setup && !pwrite && paddr == STATUS_OFFSET) begin
                prdata <= status_word;
            end else begin
                prdata <= 32'h0000_0000;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_en_reg <= CTRL_RESET[CTRL_EN_BIT];
        end else if (apb_write && paddr == CTRL_OFFSET) begin
            ctrl_en_reg <= pwdata[CTRL_EN_BIT];
        end
    end

endmodule : hsb_ctrl
`default_nettype wire

// file: shared/hsb_pkg.sv
// constants, register map and state codes of the hot swap buffer controller
// assumes a single pclk domain; pin inputs are synchronised in the top module
package hsb_pkg;
    localparam int unsigned CLK_PERIOD_NS = 8;
    localparam int unsigned IDLE_TIME_NS  = 95000;
    // least time, rounded up to whole cycles
    localparam int unsigned IDLE_CYCLES   =
        (IDLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned SYNC_STAGES   = 3;
    localparam int unsigned IN_COUNT      = 5;

    localparam logic [7:0]  CTRL_OFFSET   = 8'h00;
    localparam logic [7:0]  STATUS_OFFSET = 8'h04;
    localparam int unsigned CTRL_EN_BIT   = 0;
    localparam logic [31:0] CTRL_RESET    = 32'h0000_0001;
    localparam int unsigned STAT_ST_LSB   = 0;
    localparam int unsigned STAT_PIN_LSB  = 8;
    localparam int unsigned STAT_EN_BIT   = 12;

    // pin index inside the synchroniser vector
    localparam int unsigned PIN_BP_DAT   = 0;
    localparam int unsigned PIN_BP_CLK   = 1;
    localparam int unsigned PIN_CARD_DAT = 2;
    localparam int unsigned PIN_CARD_CLK = 3;
    localparam int unsigned PIN_ENABLE   = 4;
    localparam logic [4:0]  SYNC_RESET   = 5'h1f;

    typedef enum logic [4:0] {
        ST_LOCKOUT   = 5'h01,
        ST_WAIT_BUS  = 5'h02,
        ST_WAIT_CARD = 5'h04,
        ST_CONNECTED = 5'h08,
        ST_SHUTDOWN  = 5'h10
    } hsb_state_type;
endpackage : hsb_pkg

// file: dv/hsb_line_model.sv
// open-drain bus lines of backplane and card with their outside agents
// assumes pull-ups; order of bits is bp data, bp clock, card data, card clock
`timescale 1ns/1ps
`default_nettype none
module hsb_line_model (
    input  wire logic [3:0] drv_oe,
    input  wire logic [3:0] agent_low,
    output logic      [3:0] line
);
    // pulled-up wire, low when the buffer or any agent pulls it
    assign line = ~(drv_oe | agent_low);
endmodule : hsb_line_model
`default_nettype wire

// file: dv/hsb_ctrl_assertions.sv
// concurrent checks on the ports of hsb_ctrl
// assumes pin inputs carry the resolved wire levels
`timescale 1ns/1ps
`default_nettype none
module hsb_ctrl_assertions #(
    parameter int unsigned IDLE_COUNT = 20
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic backplane_data_line_in,
    input wire logic backplane_clock_line_in,
    input wire logic card_data_line_in,
    input wire logic card_clock_line_in,
    input wire logic enable_pin,
    input wire logic backplane_data_line_oe,
    input wire logic backplane_clock_line_oe,
    input wire logic card_data_line_oe,
    input wire logic card_clock_line_oe,
    input wire logic ready,
    input wire logic accel_enable,
    input wire logic precharge_enable,
    input wire logic low_power
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic any_oe;
    assign any_oe = backplane_data_line_oe | backplane_clock_line_oe
        | card_data_line_oe | card_clock_line_oe;

    property p_isolated; !ready |-> !any_oe; endproperty
    a_isolated: assert property (p_isolated)
        else $error("line driven while disconnected");
    property p_precharge; $rose(presetn) |-> precharge_enable; endproperty
    a_precharge: assert property (p_precharge)
        else $error("precharge off after lockout");
    property p_card_high;
        $rose(ready) |-> $past(card_data_line_in, 2)
            && $past(card_clock_line_in, 2);
    endproperty
    a_card_high: assert property (p_card_high)
        else $error("joined while card line low");
    property p_accel;
        (accel_enable == ready) && !(accel_enable && precharge_enable);
    endproperty
    a_accel: assert property (p_accel)
        else $error("accelerator state wrong");
    property p_join_card;
        (ready && !card_data_line_in && !card_data_line_oe)[*7]
            |-> backplane_data_line_oe;
    endproperty
    a_join_card: assert property (p_join_card)
        else $error("card data low not passed on");
    property p_join_bp;
        (ready && !backplane_clock_line_in && !backplane_clock_line_oe)[*7]
            |-> card_clock_line_oe;
    endproperty
    a_join_bp: assert property (p_join_bp)
        else $error("backplane clock low not passed on");
    property p_release;
        (backplane_data_line_oe && card_data_line_in)[*7]
            |-> !backplane_data_line_oe;
    endproperty
    a_release: assert property (p_release)
        else $error("data held low after release");
    property p_ready_en;
        $rose(ready) |-> enable_pin && $past(enable_pin, 3);
    endproperty
    a_ready_en: assert property (p_ready_en)
        else $error("ready without enable");
    property p_shutdown;
        (!enable_pin)[*8] |-> !ready && low_power && !precharge_enable;
    endproperty
    a_shutdown: assert property (p_shutdown)
        else $error("no shutdown with enable low");
    property p_rerun; $fell(low_power) |-> !ready ##1 !ready; endproperty
    a_rerun: assert property (p_rerun)
        else $error("reconnect without start-up");

    c_connect: cover property ($rose(ready));
    c_shut: cover property ($rose(low_power));
    c_card_drive: cover property (card_clock_line_oe);
endmodule : hsb_ctrl_assertions

bind hsb_ctrl hsb_ctrl_assertions #(.IDLE_COUNT(IDLE_COUNT)) i_chk (
    .pclk(pclk), .presetn(presetn), .enable_pin(enable_pin),
    .backplane_data_line_in(backplane_data_line_in),
    .backplane_clock_line_in(backplane_clock_line_in),
    .card_data_line_in(card_data_line_in),
    .card_clock_line_in(card_clock_line_in),
    .backplane_data_line_oe(backplane_data_line_oe),
    .backplane_clock_line_oe(backplane_clock_line_oe),
    .card_data_line_oe(card_data_line_oe),
    .card_clock_line_oe(card_clock_line_oe), .ready(ready),
    .accel_enable(accel_enable), .precharge_enable(precharge_enable),
    .low_power(low_power));
`default_nettype wire

// file: dv/testbench.sv
// self-checking bench for hsb_ctrl: apb master, line agents, scenarios
// assumes hsb_line_model resolves the four open-drain lines
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import hsb_pkg::*;
    logic        pclk, presetn, psel, penable, pwrite, enable_pin;
    logic        pready, pslverr, err, ready, ready_oe;
    logic        accel_enable, precharge_enable, low_power;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0]  oe, line, agent_low, lout;
    int          fail_count, n_tests;
    // agent pulls beside the drives they should cause
    logic [7:0]  rows [5] = '{8'h28, 8'h14, 8'h82, 8'h41, 8'ha8};

    hsb_ctrl #(.IDLE_COUNT(20)) i_hsb_ctrl (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr),
        .backplane_data_line_in(line[3]),
        .backplane_data_line_out(lout[3]),
        .backplane_data_line_oe(oe[3]),
        .backplane_clock_line_in(line[2]),
        .backplane_clock_line_out(lout[2]),
        .backplane_clock_line_oe(oe[2]),
        .card_data_line_in(line[1]), .card_data_line_out(lout[1]),
        .card_data_line_oe(oe[1]),
        .card_clock_line_in(line[0]), .card_clock_line_out(lout[0]),
        .card_clock_line_oe(oe[0]), .enable_pin(enable_pin),
        .ready(ready), .ready_oe(ready_oe), .accel_enable(accel_enable),
        .precharge_enable(precharge_enable), .low_power(low_power));
    hsb_line_model i_hsb_line_model (
        .drv_oe(oe), .agent_low(agent_low), .line(line));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk

    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wait_rdy(input int n);
        for (int i = 0; i < n && ready !== 1'b1; i++)
            @(posedge pclk);
    endtask : wait_rdy

    task automatic close_out;
        $display("mismatches %0d of %0d checks", fail_count, n_tests);
        if (fail_count == 0 && n_tests > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : close_out

    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end
    initial begin
        #20000;
        fail_count++;
        close_out();
    end
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        {fail_count, n_tests} = '0;
        enable_pin = 1'b1;
        agent_low = 4'h9;
        repeat (5) @(posedge pclk);
        chk({ready, ready_oe, precharge_enable, low_power, oe}, 8'h60);
        presetn <= 1'b1;
        repeat (10) @(posedge pclk);
        agent_low <= 4'h1;
        repeat (40) @(posedge pclk);
        chk(ready, 1'b0);
        agent_low <= 4'h0;
        wait_rdy(12);
        chk({ready, ready_oe, accel_enable, precharge_enable}, 4'ha);
        apb(1'b0, STATUS_OFFSET, 32'h0);
        chk(rd, 32'h0000_1f08);
        apb(1'b0, 8'h08, 32'h0);
        chk({err, rd[30:0]}, 32'h8000_0000);
        apb(1'b0, CTRL_OFFSET, 32'h0);
        chk(rd, CTRL_RESET);
        for (int i = 0; i < 5; i++) begin
            agent_low <= rows[i][7:4];
            repeat (8) @(posedge pclk);
            chk(oe, rows[i][3:0]);
            chk(lout, 4'h0);
            agent_low <= 4'h0;
            repeat (8) @(posedge pclk);
            chk({ready, oe}, 5'h10);
        end
        // backplane clock at the link rate
        repeat (16) begin
            agent_low <= agent_low ^ 4'h4;
            repeat (10) @(posedge pclk);
            chk(line[0], line[2]);
        end
        apb(1'b1, CTRL_OFFSET, 32'h0);
        repeat (3) @(posedge pclk);
        chk({ready, low_power, precharge_enable, oe}, 7'h20);
        agent_low <= 4'h8;
        apb(1'b1, CTRL_OFFSET, 32'h1);
        repeat (40) @(posedge pclk);
        chk(ready, 1'b0);
        agent_low <= 4'h0;
        wait_rdy(12);
        chk(ready, 1'b1);
        enable_pin <= 1'b0;
        repeat (10) @(posedge pclk);
        chk({ready, low_power}, 2'b01);
        enable_pin <= 1'b1;
        repeat (15) @(posedge pclk);
        chk(ready, 1'b0);
        wait_rdy(30);
        chk(ready, 1'b1);
        close_out();
    end
endmodule : testbench
`default_nettype wire
